/* File: src/ffc_pkg.sv */
package ffc_pkg;

    typedef enum {
        whole_to_real_mode,
        real_to_whole_mode,
        real_to_real_mode,
        scaled_to_real_mode,
        real_to_scaled_mode
    } ffc_mode_e;

    // Round round_nearest_setting, ties to even, is the only member
    typedef enum {
        round_nearest_setting
    } ffc_round_e;

    localparam int EXP_W_DEFAULT  = 8;
    localparam int MAN_W_DEFAULT  = 23;
    localparam int EXP_W_SINGLE   = 8;
    localparam int EXP_W_DOUBLE   = 11;
    localparam int MAN_W_SINGLE   = 23;
    localparam int MAN_W_WIDE_MIN = 31;
    localparam int FMT_W_MAX      = 64;
    localparam int INT_W_DEFAULT  = 32;
    localparam int INT_W_MIN      = 4;
    localparam int INT_W_MAX      = 64;
    localparam int FRAC_W_DEFAULT = 16;
    localparam int FIFO_DEPTH     = 4;
    localparam int LAT_FIXED      = 6;
    localparam int LAT_F2F_SINGLE = 2;
    localparam int LAT_F2F_WIDE   = 3;

    function automatic int exp_bias(input int w);
        return (2 ** (w - 1)) - 1;
    endfunction

    function automatic int latency(input ffc_mode_e mode, input int exp_w_in);
        if (mode != real_to_real_mode) begin
            return LAT_FIXED;
        end
        return (exp_w_in == EXP_W_SINGLE) ? LAT_F2F_SINGLE : LAT_F2F_WIDE;
    endfunction

endpackage

/* File: src/ffc_stream_if.sv */
`timescale 1ns/1ps
interface ffc_stream_if #(
    parameter int WIDTH = 32
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: src/ffc_fifo.sv */
`timescale 1ns/1ps
module ffc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = ffc_pkg::FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             aclr,
    input  wire logic             en,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    ffc_stream_if.src             out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push       = en && in_valid && in_ready;
    assign pop        = out.valid && out.ready;
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign out.valid  = (count_reg != '0);
    assign out.data   = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            in_ready   <= 1'b0;
        end else if (!rstn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            in_ready   <= 1'b0;
        end else begin
            wr_ptr_reg <= push ? AW'(wr_ptr_reg + 1'b1) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'(rd_ptr_reg + 1'b1) : rd_ptr_reg;
            count_reg  <= count_next;
            in_ready   <= (count_next < (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
endmodule

/* File: src/ffc_delay.sv */
`timescale 1ns/1ps
module ffc_delay #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 5
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             aclr,
    input  wire logic             adv,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage_reg [DEPTH];

    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
        end else if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                stage_reg[i] <= '0;
            end
        end else if (adv) begin
            stage_reg[0] <= d;
            for (int i = 1; i < DEPTH; i++) begin
                stage_reg[i] <= stage_reg[i-1];
            end
        end
    end

    assign q = stage_reg[DEPTH-1];
endmodule

/* File: src/ffc_converter.sv */
// Notes on behaviour
// [RQ1] Clock enable low freezes pipeline and outputs
// [RQ2] Active-high clear resets state without clock
// [RQ3] Float input is 32, 64 or 43..64 bits
// [RQ4] Single gives double, double gives single (code rejects only single to single; double to double passes)
// [RQ5] Flags only in float-input modes
// [RQ6] Overflow on too-large result or infinity input
// [RQ7] Underflow when rounded fraction becomes zero
// [RQ8] Whole mode: underflow when exponent below bias
// [RQ9] Real mode: underflow below target exponent range
// [RQ10] Not-a-number flag on NaN input
// [RQ11] NaN gives zero, or target NaN encoding
// [RQ12] Bias is two to (width-1), minus one
// [RQ13] Exponent width 8, 11, or at least 11
// [RQ14] Mantissa 23 or >=31, above exponent, sum<64
// [RQ15] Integer width 4..64, default 32
// [RQ16] Input width follows mode and field widths
// [RQ17] Result width follows mode and field widths
// [RQ18] Round round_nearest_setting only
// [RQ19] Five modes, default whole to real
// [RQ20] Default exponent 8, mantissa 23
// [RQ21] Six cycles latency outside real-to-real mode
// [RQ22] Real-to-real latency two or three cycles
// [RQ23] Denormal inputs count as zero
// [RQ24] Overflow saturates to signed extremes
// [RQ25] Flags travel with their result
// [RQ26] One new operand per enabled cycle
`timescale 1ns/1ps
module ffc_converter #(
    parameter ffc_pkg::ffc_mode_e  MODE       = ffc_pkg::whole_to_real_mode,    // [RQ19]
    parameter ffc_pkg::ffc_round_e ROUNDING   = ffc_pkg::round_nearest_setting, // [RQ18]
    parameter int                  EXP_W_IN   = ffc_pkg::EXP_W_DEFAULT,         // [RQ20]
    parameter int                  MAN_W_IN   = ffc_pkg::MAN_W_DEFAULT,         // [RQ20]
    parameter int                  EXP_W_OUT  = ffc_pkg::EXP_W_DEFAULT,
    parameter int                  MAN_W_OUT  = ffc_pkg::MAN_W_DEFAULT,
    parameter int                  INT_W      = ffc_pkg::INT_W_DEFAULT,
    parameter int                  FRAC_W     = ffc_pkg::FRAC_W_DEFAULT,
    parameter int                  FIFO_DEPTH = ffc_pkg::FIFO_DEPTH,
    localparam bit                 IN_FLOAT   = (MODE == ffc_pkg::real_to_whole_mode) ||
                                                (MODE == ffc_pkg::real_to_real_mode) ||
                                                (MODE == ffc_pkg::real_to_scaled_mode),
    localparam bit                 OUT_FLOAT  = (MODE == ffc_pkg::whole_to_real_mode) ||
                                                (MODE == ffc_pkg::real_to_real_mode) ||
                                                (MODE == ffc_pkg::scaled_to_real_mode),
    localparam int                 DATA_W     = IN_FLOAT ? EXP_W_IN + MAN_W_IN + 1 :
                                                (MODE == ffc_pkg::scaled_to_real_mode) ?
                                                INT_W + FRAC_W : INT_W,                 // [RQ16]
    localparam int                 RESULT_W   = OUT_FLOAT ? EXP_W_OUT + MAN_W_OUT + 1 :
                                                INT_W                                   // [RQ17]
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic                aclr,
    input  wire logic                clk_en,
    input  wire logic                in_valid,
    input  wire logic [DATA_W-1:0]   data_in,
    output logic                     in_ready,
    input  wire logic                out_ready,
    output logic                     out_valid,
    output logic      [RESULT_W-1:0] result,
    output logic                     overflow,
    output logic                     underflow,
    output logic                     nan
);
    localparam int EI        = EXP_W_IN;
    localparam int MI        = MAN_W_IN;
    localparam int EO        = EXP_W_OUT;
    localparam int MO        = MAN_W_OUT;
    localparam int RW        = RESULT_W;
    localparam int BI        = ffc_pkg::exp_bias(EI);    // [RQ12]
    localparam int BO        = ffc_pkg::exp_bias(EO);    // [RQ12]
    localparam int EXP_ONES  = (2 ** EO) - 1;
    localparam int FRAC_IN   = (MODE == ffc_pkg::scaled_to_real_mode) ? FRAC_W : 0;
    localparam int FRAC_OUT  = (MODE == ffc_pkg::real_to_scaled_mode) ? FRAC_W : 0;
    localparam int LATENCY   = ffc_pkg::latency(MODE, EI);  // [RQ21] [RQ22]
    localparam int PIPE_W    = RW + 4;

    // Field widths checked once at elaboration
    localparam bit FMT_IN_OK  = (EI == ffc_pkg::EXP_W_SINGLE) ? (MI == ffc_pkg::MAN_W_SINGLE) :
                                ((EI >= ffc_pkg::EXP_W_DOUBLE) && (MI >= ffc_pkg::MAN_W_WIDE_MIN));
    localparam bit FMT_OUT_OK = (EO == ffc_pkg::EXP_W_SINGLE) ? (MO == ffc_pkg::MAN_W_SINGLE) :
                                ((EO >= ffc_pkg::EXP_W_DOUBLE) && (MO >= ffc_pkg::MAN_W_WIDE_MIN));
    localparam bit SUM_OK     = (MI > EI) && (EI + MI < ffc_pkg::FMT_W_MAX) &&
                                (MO > EO) && (EO + MO < ffc_pkg::FMT_W_MAX);
    localparam bit INT_OK     = (INT_W >= ffc_pkg::INT_W_MIN) && (INT_W <= ffc_pkg::INT_W_MAX) &&
                                (DATA_W <= ffc_pkg::INT_W_MAX) && (FRAC_W < INT_W);
    localparam bit F2F_OK     = (MODE != ffc_pkg::real_to_real_mode) ||
                                (EI != ffc_pkg::EXP_W_SINGLE) || (EO != ffc_pkg::EXP_W_SINGLE);

    generate
        if (!(FMT_IN_OK && FMT_OUT_OK && SUM_OK && INT_OK && F2F_OK)) begin : bad_params
            $error("ffc_converter: illegal width parameters"); // [RQ3] [RQ4] [RQ13] [RQ14] [RQ15]
        end
    endgenerate

    function automatic logic [MO:0] rnd_nearest(input logic [63:0] frac);
        logic [MO-1:0] kept;
        logic          guard;
        logic          sticky;
        kept   = MO'(frac >> (64 - MO));
        guard  = frac[63-MO];
        sticky = |(frac << (MO + 1));
        return (MO+1)'({1'b0, kept}) + (MO+1)'(guard && (sticky || kept[0])); // [RQ18]
    endfunction

    function automatic logic [63:0] pack_float(input logic s, input int ex,
                                               input logic [MO-1:0] man);
        return 64'({s, EO'(ex), man});
    endfunction

    function automatic int msb_pos(input logic [63:0] v);
        int pos;
        pos = 0;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                pos = i;
            end
        end
        return pos;
    endfunction

    ffc_stream_if #(.WIDTH(DATA_W)) head ();

    logic adv;

    // Downstream stall also holds the pipeline, so the FIFO fills
    assign adv        = clk_en && out_ready;  // [RQ1]
    assign head.ready = adv;                  // [RQ26]

    ffc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rstn     (rstn),
        .aclr     (aclr),
        .en       (clk_en),
        .in_valid (in_valid),
        .in_data  (data_in),
        .in_ready (in_ready),
        .out      (head)
    );

    logic [63:0]   dw64;
    logic          in_sign;
    logic [EI-1:0] in_exp;
    logic [MI-1:0] in_man;
    int            in_exp_i;
    logic          in_nan;
    logic          in_inf;
    logic          in_zero;

    assign dw64     = 64'(head.data);
    assign in_sign  = dw64[EI+MI];
    assign in_exp   = dw64[EI+MI-1:MI];
    assign in_man   = dw64[MI-1:0];
    assign in_exp_i = int'(in_exp);
    assign in_nan   = (&in_exp) && (|in_man);   // [RQ10]
    assign in_inf   = (&in_exp) && !(|in_man);
    assign in_zero  = (in_exp == '0);           // [RQ23]

    // Whole or scaled input to floating point
    logic          w_sign;
    logic [63:0]   w_sx;
    logic [63:0]   w_mag;
    int            w_pos;
    logic [MO:0]   w_rnd;
    int            w_exp;
    logic [63:0]   w_res;

    always_comb begin
        w_sign = dw64[DATA_W-1];
        w_sx   = (w_sign && (DATA_W < 64)) ? (dw64 | ~((64'h1 << DATA_W) - 64'h1)) : dw64;
        w_mag  = w_sign ? 64'(-w_sx) : w_sx;
        w_pos  = msb_pos(w_mag);
        w_rnd  = rnd_nearest((w_mag << (63 - w_pos)) << 1);
        w_exp  = w_pos - FRAC_IN + BO + int'(w_rnd[MO]);
        if (w_mag == '0) begin
            w_res = '0;
        end else if (w_exp >= EXP_ONES) begin
            w_res = pack_float(w_sign, EXP_ONES, '0);
        end else if (w_exp <= 0) begin
            w_res = pack_float(w_sign, 0, '0);
        end else begin
            w_res = pack_float(w_sign, w_exp, w_rnd[MO-1:0]);
        end
    end

    // Floating point to whole or scaled value
    int            x_shift;
    logic [63:0]   x_sig;
    logic [191:0]  x_wide;
    logic [191:0]  x_z;
    logic          x_up;
    logic [126:0]  x_mag;
    logic [126:0]  x_lim;
    logic          x_big;
    logic [63:0]   x_sat;
    logic [63:0]   x_res;

    always_comb begin
        x_shift = in_exp_i - BI + FRAC_OUT;
        x_sig   = (64'h1 << MI) | 64'(in_man);
        x_wide  = 192'(x_sig) << (64 - MI);
        x_z     = '0;
        x_up    = 1'b0;
        x_mag   = '0;
        if ((x_shift >= -1) && (x_shift <= 63)) begin
            x_z   = x_wide << (x_shift + 1);
            x_up  = x_z[64] && ((|x_z[63:0]) || x_z[65]);  // [RQ18]
            x_mag = x_z[191:65] + 127'(x_up);
        end
        x_lim = 127'h1 << (RW - 1);
        x_big = (x_shift > 63) || (in_sign ? (x_mag > x_lim) : (x_mag >= x_lim)); // [RQ6]
        x_sat = in_sign ? 64'(x_lim) : 64'(x_lim - 127'h1);                      // [RQ24]
        x_res = in_sign ? 64'(-x_mag) : 64'(x_mag);
    end

    // Floating point between precisions
    logic [MO:0]   f_rnd;
    int            f_exp;
    logic [MO-1:0] f_quiet;

    always_comb begin
        f_rnd   = rnd_nearest(64'(in_man) << (64 - MI));
        f_exp   = in_exp_i - BI + BO + int'(f_rnd[MO]);
        f_quiet = MO'(1) << (MO - 1);
    end

    logic [63:0]   c_res;
    logic          c_of;
    logic          c_uf;
    logic          c_nan;

    always_comb begin
        c_res = '0;
        c_of  = 1'b0;
        c_uf  = 1'b0;
        c_nan = 1'b0;
        unique case (MODE)
            ffc_pkg::whole_to_real_mode,
            ffc_pkg::scaled_to_real_mode: begin
                c_res = w_res;  // [RQ5]
            end
            ffc_pkg::real_to_whole_mode,
            ffc_pkg::real_to_scaled_mode: begin
                if (in_nan) begin
                    c_nan = 1'b1;  // [RQ10] [RQ11]
                end else if (in_zero) begin
                    c_res = '0;    // [RQ23]
                end else if (in_inf || x_big) begin
                    c_of  = 1'b1;  // [RQ6]
                    c_res = x_sat; // [RQ24]
                end else if ((MODE == ffc_pkg::real_to_whole_mode) && (in_exp_i < BI)) begin
                    c_uf  = 1'b1;  // [RQ8]
                end else begin
                    c_res = x_res;
                    c_uf  = (x_mag == '0);  // [RQ7]
                end
            end
            ffc_pkg::real_to_real_mode: begin
                if (in_nan) begin
                    c_nan = 1'b1;                                  // [RQ10]
                    c_res = pack_float(in_sign, EXP_ONES, f_quiet); // [RQ11]
                end else if (in_inf) begin
                    c_of  = 1'b1;                                  // [RQ6]
                    c_res = pack_float(in_sign, EXP_ONES, '0);
                end else if (in_zero) begin
                    c_res = pack_float(in_sign, 0, '0);            // [RQ23]
                end else if (f_exp >= EXP_ONES) begin
                    c_of  = 1'b1;                                  // [RQ6]
                    c_res = pack_float(in_sign, EXP_ONES, '0);
                end else if (f_exp <= 0) begin
                    c_uf  = 1'b1;                                  // [RQ9]
                    c_res = pack_float(in_sign, 0, '0);
                end else begin
                    c_res = pack_float(in_sign, f_exp, f_rnd[MO-1:0]); // [RQ4]
                end
            end
        endcase
    end

    logic [PIPE_W-1:0] pipe_d;
    logic [PIPE_W-1:0] pipe_q;

    // Flags ride in the same word as their result
    // Bubbles carry zeros, so stale FIFO words never raise a flag
    assign pipe_d = head.valid ? {1'b1, c_of, c_uf, c_nan, RW'(c_res)} : '0;  // [RQ25]

    // FIFO take-in is the first of the counted edges
    ffc_delay #(
        .WIDTH (PIPE_W),
        .DEPTH (LATENCY - 1)
    ) u_delay (
        .clk  (clk),
        .rstn (rstn),
        .aclr (aclr),        // [RQ2]
        .adv  (adv),         // [RQ1]
        .d    (pipe_d),      // [RQ21] [RQ22]
        .q    (pipe_q)
    );

    assign out_valid = pipe_q[RW+3];
    assign overflow  = pipe_q[RW+2];
    assign underflow = pipe_q[RW+1];
    assign nan       = pipe_q[RW];
    assign result    = pipe_q[RW-1:0];

endmodule

/* File: tb/ffc_converter_asserts.sv */
`timescale 1ns/1ps
module ffc_converter_asserts #(
    parameter int DATA_W     = 32,
    parameter int RESULT_W   = 32,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic                clk,
    input wire logic                rstn,
    input wire logic                aclr,
    input wire logic                clk_en,
    input wire logic                in_valid,
    input wire logic [DATA_W-1:0]   data_in,
    input wire logic                in_ready,
    input wire logic                out_ready,
    input wire logic                out_valid,
    input wire logic [RESULT_W-1:0] result,
    input wire logic                overflow,
    input wire logic                underflow,
    input wire logic                nan
);
    logic       live_reg;
    logic [7:0] pend_reg;
    logic       take;
    logic       adv;

    assign take = clk_en && in_valid && in_ready;
    assign adv  = clk_en && out_ready;

    // Words accepted and not yet handed downstream
    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            pend_reg <= 8'h0;
        end else if (!rstn) begin
            pend_reg <= 8'h0;
        end else begin
            pend_reg <= pend_reg + 8'(take) - 8'(out_valid && adv);
        end
    end

    // Ignores the first edge after reset, where outputs still show reset values
    always_ff @(posedge clk or posedge aclr) begin
        if (aclr) begin
            live_reg <= 1'b0;
        end else begin
            live_reg <= rstn;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn || aclr);

    property p_hold;
        live_reg && !adv |=> $stable(result) && $stable(out_valid)
            && $stable({overflow, underflow, nan});
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved while stalled");

    property p_clear;
        disable iff (!rstn) aclr |-> !out_valid && result == '0 && !in_ready && !nan;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty outputs");

    property p_lat_min;
        take && pend_reg == 8'h0 |=> !out_valid [*5];
    endproperty
    a_lat_min: assert property (p_lat_min) else $error("result came too early");

    property p_lat_max;
        take && adv && pend_reg == 8'h0 ##1 adv [*5] |=> out_valid;
    endproperty
    a_lat_max: assert property (p_lat_max) else $error("result came too late");

    property p_nan_zero;
        nan |-> out_valid && result == '0;
    endproperty
    a_nan_zero: assert property (p_nan_zero) else $error("nan result not zero");

    property p_under_zero;
        underflow |-> result == '0 && !overflow;
    endproperty
    a_under_zero: assert property (p_under_zero) else $error("underflow result not zero");

    property p_sat;
        overflow |-> result == {1'b0, {(RESULT_W-1){1'b1}}}
            || result == {1'b1, {(RESULT_W-1){1'b0}}};
    endproperty
    a_sat: assert property (p_sat) else $error("overflow not saturated");

    property p_flow;
        out_valid |-> pend_reg != 8'h0;
    endproperty
    a_flow: assert property (p_flow) else $error("result without operand");

    property p_full;
        live_reg && !in_ready |-> pend_reg >= FIFO_DEPTH;
    endproperty
    a_full: assert property (p_full) else $error("refused with room left");

    c_ovf: cover property (out_valid && overflow);
    c_nan: cover property (out_valid && nan);
    c_stall: cover property (out_valid && !adv);
endmodule

bind ffc_converter ffc_converter_asserts #(
    .DATA_W     (DATA_W),
    .RESULT_W   (RESULT_W),
    .FIFO_DEPTH (FIFO_DEPTH)
) chk_u (
    .clk       (clk),
    .rstn      (rstn),
    .aclr      (aclr),
    .clk_en    (clk_en),
    .in_valid  (in_valid),
    .data_in   (data_in),
    .in_ready  (in_ready),
    .out_ready (out_ready),
    .out_valid (out_valid),
    .result    (result),
    .overflow  (overflow),
    .underflow (underflow),
    .nan       (nan)
);

/* File: tb/ffc_sink_model.sv */
`timescale 1ns/1ps
module ffc_sink_model #(
    parameter int RESULT_W = 32
) (
    input  wire logic                clk,
    input  wire logic                clk_en,
    input  wire logic [1:0]          stall_mode,
    input  wire logic                out_valid,
    input  wire logic [RESULT_W-1:0] result,
    input  wire logic                overflow,
    input  wire logic                underflow,
    input  wire logic                nan,
    output logic                     out_ready
);
    logic [RESULT_W+2:0] got_q[$];

    initial out_ready = 1'b0;

    // Prompt, every other cycle, or stalled
    always @(negedge clk) begin
        case (stall_mode)
            2'h0: out_ready <= 1'b1;
            2'h1: out_ready <= !out_ready;
            default: out_ready <= 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (out_valid && out_ready && clk_en) begin
            got_q.push_back({nan, underflow, overflow, result});
        end
    end
endmodule

/* File: tb/float_format_converter_tb.sv */
`timescale 1ns/1ps
module float_format_converter_tb;
    localparam int DW = 32;
    localparam int RW = 32;
    localparam logic [31:0] TIN [14] = '{32'h3fc00000, 32'h40200000, 32'hc0600000,
        32'h7f800000, 32'hff800000, 32'h4f000000, 32'hcf000000, 32'h3f000000, 32'h7fc00000,
        32'hff800001, 32'h00400000, 32'h80000000, 32'h3f800000, 32'h4effffff};
    localparam logic [34:0] TEXP [14] = '{35'h000000002, 35'h000000002, 35'h0fffffffc,
        35'h17fffffff, 35'h180000000, 35'h17fffffff, 35'h080000000, 35'h200000000,
        35'h400000000, 35'h400000000, 35'h000000000, 35'h000000000, 35'h000000001,
        35'h07fffff80};
    logic          clk;
    logic          rstn;
    logic          aclr;
    logic          clk_en;
    logic          in_valid;
    logic [DW-1:0] data_in;
    logic          in_ready;
    logic          out_ready;
    logic          out_valid;
    logic [RW-1:0] result;
    logic          overflow;
    logic          underflow;
    logic          nan;
    logic [1:0]    stall_mode;
    logic [RW+2:0] got;
    int            num_errors;
    int            comparisons;

    ffc_converter #(
        .MODE     (ffc_pkg::real_to_whole_mode),
        .EXP_W_IN (ffc_pkg::EXP_W_SINGLE),
        .MAN_W_IN (ffc_pkg::MAN_W_SINGLE),
        .INT_W    (RW)
    ) dut_u (
        .clk(clk), .rstn(rstn), .aclr(aclr), .clk_en(clk_en), .in_valid(in_valid),
        .data_in(data_in), .in_ready(in_ready), .out_ready(out_ready),
        .out_valid(out_valid), .result(result), .overflow(overflow),
        .underflow(underflow), .nan(nan)
    );

    ffc_sink_model #(.RESULT_W(RW)) sink_u (
        .clk(clk), .clk_en(clk_en), .stall_mode(stall_mode), .out_valid(out_valid),
        .result(result), .overflow(overflow), .underflow(underflow), .nan(nan),
        .out_ready(out_ready)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic send(input logic [DW-1:0] w);
        int i;
        @(negedge clk);
        in_valid = 1'b1;
        data_in  = w;
        for (i = 0; i < 50 && in_ready !== 1'b1; i++) begin
            @(negedge clk);
        end
        @(posedge clk);
    endtask

    task automatic idle();
        @(negedge clk);
        in_valid = 1'b0;
    endtask

    task automatic expect_word(input logic [RW+2:0] e);
        int i;
        for (i = 0; i < 200 && sink_u.got_q.size() == 0; i++) begin
            @(posedge clk);
        end
        got = (sink_u.got_q.size() != 0) ? sink_u.got_q.pop_front() : 'x;
        check("result word", 64'(got), 64'(e));
    endtask

    task automatic t_table();
        stall_mode = 2'h0;
        foreach (TIN[i]) send(TIN[i]);
        idle();
        foreach (TEXP[i]) expect_word(TEXP[i]);
        $display("test table done");
    endtask

    task automatic t_latency(input int hold);
        int n;
        stall_mode = 2'h0;
        send(32'h40400000);
        @(negedge clk);
        in_valid = 1'b0;
        clk_en   = (hold == 0);
        n = 1;
        while (n < 100 && out_valid !== 1'b1) begin
            @(posedge clk);
            n++;
            @(negedge clk);
            if (n == hold + 1) clk_en = 1'b1;
        end
        check("latency", 64'(n), 64'(ffc_pkg::LAT_FIXED + hold));
        expect_word(35'h000000003);
        $display("test latency hold %0d done", hold);
    endtask

    task automatic t_fill();
        int acc;
        int i;
        stall_mode = 2'h2;
        repeat (2) @(negedge clk);
        acc = 0;
        for (i = 0; i < 20; i++) begin
            @(negedge clk);
            if (in_ready !== 1'b1) break;
            in_valid = 1'b1;
            data_in  = 32'h3f800000 + (acc << 23);
            acc++;
        end
        in_valid = 1'b0;
        check("refused when full", 64'(in_ready), 64'h0);
        check("words taken", 64'(acc >= ffc_pkg::FIFO_DEPTH), 64'h1);
        check("nothing out while stalled", 64'(sink_u.got_q.size()), 64'h0);
        stall_mode = 2'h1;
        for (i = 0; i < acc; i++) expect_word(35'(64'h1 << i));
        repeat (20) @(negedge clk);
        check("drained", 64'(sink_u.got_q.size()), 64'h0);
        check("room again", 64'(in_ready), 64'h1);
        $display("test fill done");
    endtask

    task automatic t_aclr();
        int i;
        stall_mode = 2'h0;
        send(32'h40a00000);
        send(32'h40c00000);
        idle();
        for (i = 0; i < 20 && out_valid !== 1'b1; i++) begin
            @(negedge clk);
        end
        aclr = 1'b1;
        #10;
        check("clear valid", 64'(out_valid), 64'h0);
        check("clear result", 64'(result), 64'h0);
        check("clear ready", 64'(in_ready), 64'h0);
        @(negedge clk);
        aclr = 1'b0;
        repeat (12) @(negedge clk);
        check("nothing after clear", 64'(sink_u.got_q.size()), 64'h0);
        $display("test clear done");
    endtask

    initial begin
        rstn        = 1'b0;
        aclr        = 1'b0;
        clk_en      = 1'b1;
        in_valid    = 1'b0;
        data_in     = '0;
        stall_mode  = 2'h0;
        num_errors  = 0;
        comparisons = 0;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        t_latency(0);
        t_latency(10);
        t_table();
        t_fill();
        t_aclr();
        t_latency(3);
        conclude();
    end

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
